// ===== rtl/sbx_pkg.sv
`default_nettype none

package sbx_pkg;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_INSTR = 8'h04;
  localparam logic [7:0] ADDR_ACC = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_FADDR = 8'h10;
  localparam logic [7:0] ADDR_FDATA = 8'h14;

  localparam int CTRL_ISSUE_BIT = 0;
  localparam int CTRL_WAKE_BIT = 1;
  localparam int STAT_C_BIT = 0;
  localparam int STAT_NIB_BIT = 1;
  localparam int STAT_Z_BIT = 2;
  localparam int STAT_SLEEP_BIT = 3;
  localparam int STAT_BUSY_BIT = 4;
  localparam int STAT_BADOP_BIT = 5;

  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [13:0] INSTR_RST = 14'h0000;
  localparam logic [6:0] FADDR_RST = 7'h00;
  localparam logic FLAG_RST = 1'b0;

  // ************************************************************
  // Phase timing
  // ************************************************************
  localparam int PHASE_DIV = 2;
  localparam logic [3:0] PHASE_LAST = 4'(PHASE_DIV - 1);
  localparam logic [3:0] PHASE_FIRST = 4'h1;

  // ************************************************************
  // Instruction encodings
  // ************************************************************
  localparam logic [13:0] LIT_MASK = 14'h3e00;
  localparam logic [13:0] LIT_PAT = 14'h3c00;
  localparam logic [13:0] REG_MASK = 14'h3f00;
  localparam logic [13:0] REG_PAT = 14'h0200;
  localparam logic [13:0] SLEEP_CODE = 14'h0063;
  localparam int DEST_BIT = 7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_SLEEP = 3'b100
  } sbx_state_t;

  typedef enum logic [3:0] {
    K_NONE = 4'b0001,
    K_LIT = 4'b0010,
    K_REG = 4'b0100,
    K_SLEEP = 4'b1000
  } sbx_kind_t;

  function automatic logic [8:0] add9(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic cin);
    return {1'b0, a} + {1'b0, b} + {8'h00, cin};
  endfunction

endpackage

`default_nettype wire

// ===== rtl/sbx_alu_if.sv
`timescale 1ns/10ps
`default_nettype none

interface sbx_alu_if;
  logic [7:0] minuend;
  logic [7:0] subtrahend;
  logic [7:0] diff;
  logic carry;
  logic nib_carry;
  logic zero;

  modport core (output minuend, output subtrahend, input diff,
                input carry, input nib_carry, input zero);
  modport alu (input minuend, input subtrahend, output diff,
               output carry, output nib_carry, output zero);
endinterface

`default_nettype wire

// ===== rtl/sbx_sub_alu.sv
`timescale 1ns/10ps
`default_nettype none

module sbx_sub_alu (
  sbx_alu_if.alu bus
);
  logic [8:0] full_sum;
  logic [8:0] low_sum;

  // Borrow is the inverse of the carry out of a + ~b + 1
  always_comb begin
    full_sum = sbx_pkg::add9(bus.minuend, ~bus.subtrahend, 1'b1);
    low_sum = sbx_pkg::add9({4'h0, bus.minuend[3:0]},
                            {4'h0, ~bus.subtrahend[3:0]}, 1'b1);
    bus.diff = full_sum[7:0];
    bus.carry = full_sum[8];
    bus.nib_carry = low_sum[4];
    bus.zero = (full_sum[7:0] == 8'h00);
  end
endmodule

`default_nettype wire

// ===== rtl/sbx_phase_gen.sv
`timescale 1ns/10ps
`default_nettype none

module sbx_phase_gen (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic run,
  output logic q_stb,
  output logic [3:0] q_sel
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [3:0] sel_reg;
  logic [3:0] sel_next;

  // Phases only advance while running: a stopped core sees no edges
  always_comb begin
    q_stb = run && (cnt_reg == sbx_pkg::PHASE_LAST);
    cnt_next = 4'h0;
    sel_next = sbx_pkg::PHASE_FIRST;
    if (run) begin
      cnt_next = q_stb ? 4'h0 : cnt_reg + 4'h1;
      sel_next = q_stb ? {sel_reg[2:0], sel_reg[3]} : sel_reg;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 4'h0;
      sel_reg <= sbx_pkg::PHASE_FIRST;
    end else begin
      cnt_reg <= cnt_next;
      sel_reg <= sel_next;
    end
  end

  assign q_sel = sel_reg;
endmodule

`default_nettype wire

// ===== rtl/sbx_sub_exec.sv
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module sbx_sub_exec (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic core_sleep
);
  // ************************************************************
  // State
  // ************************************************************
  sbx_pkg::sbx_state_t st_reg, st_next;
  sbx_pkg::sbx_kind_t kind_reg, kind_next;
  logic [13:0] instr_reg, instr_next;
  logic [7:0] acc_reg, acc_next;
  logic [6:0] faddr_reg, faddr_next;
  logic [7:0] op_reg, op_next;
  logic [7:0] res_reg, res_next;
  logic nc_reg, nc_next, ndc_reg, ndc_next, nz_reg, nz_next;
  logic c_reg, c_next, nib_reg, nib_next, z_reg, z_next;
  logic badop_reg, badop_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [7:0] file_mem [128];
  logic mem_we;
  logic [6:0] mem_addr;
  logic [7:0] mem_wdata;
  logic q_stb;
  logic [3:0] q_sel;
  logic run;
  logic q1, q2, q3, q4;
  logic wr_ok, wr, rd_setup, busy, dest_reg;
  logic [7:0] wbyte;

  sbx_alu_if alu_bus ();

  sbx_sub_alu u_alu (
    .bus(alu_bus.alu)
  );

  sbx_phase_gen u_phase (
    .core_clk(core_clk),
    .rst(rst),
    .run(run),
    .q_stb(q_stb),
    .q_sel(q_sel)
  );

  function automatic logic addr_ok(input logic [7:0] a);
    return a == sbx_pkg::ADDR_CTRL || a == sbx_pkg::ADDR_INSTR ||
           a == sbx_pkg::ADDR_ACC || a == sbx_pkg::ADDR_STATUS ||
           a == sbx_pkg::ADDR_FADDR || a == sbx_pkg::ADDR_FDATA;
  endfunction

  // ************************************************************
  // Bus and phase decode
  // ************************************************************
  assign busy = (st_reg == sbx_pkg::ST_RUN);
  assign run = busy;
  assign q1 = busy && q_stb && q_sel[0];
  assign q2 = busy && q_stb && q_sel[1];
  assign q3 = busy && q_stb && q_sel[2];
  assign q4 = busy && q_stb && q_sel[3];
  assign dest_reg = instr_reg[sbx_pkg::DEST_BIT];
  assign wbyte = pwdata[7:0];
  // Zero-wait slave; writes are refused while an instruction is in flight
  // so software cannot race the datapath.
  assign wr = psel && penable && pwrite && pstrb[0];
  assign wr_ok = wr && addr_ok(paddr) && !busy;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable &&
                   (!addr_ok(paddr) || (pwrite && busy));
  assign prdata = prdata_reg;
  assign core_sleep = (st_reg == sbx_pkg::ST_SLEEP);
  assign alu_bus.minuend = op_reg;
  assign alu_bus.subtrahend = acc_reg;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    kind_next = kind_reg;
    instr_next = instr_reg;
    acc_next = acc_reg;
    faddr_next = faddr_reg;
    op_next = op_reg;
    res_next = res_reg;
    nc_next = nc_reg;
    ndc_next = ndc_reg;
    nz_next = nz_reg;
    c_next = c_reg;
    nib_next = nib_reg;
    z_next = z_reg;
    badop_next = badop_reg;
    prdata_next = prdata_reg;
    mem_we = 1'b0;
    mem_addr = faddr_reg;
    mem_wdata = wbyte;

    if (rd_setup) begin
      unique case (paddr)
        sbx_pkg::ADDR_INSTR: prdata_next = {18'h00000, instr_reg};
        sbx_pkg::ADDR_ACC: prdata_next = {24'h000000, acc_reg};
        sbx_pkg::ADDR_STATUS: prdata_next = {26'h0000000, badop_reg,
            busy, core_sleep, z_reg, nib_reg, c_reg};
        sbx_pkg::ADDR_FADDR: prdata_next = {25'h0000000, faddr_reg};
        sbx_pkg::ADDR_FDATA: prdata_next = {24'h000000,
            file_mem[faddr_reg]};
        default: prdata_next = 32'h00000000;
      endcase
    end

    if (wr_ok) begin
      unique case (paddr)
        sbx_pkg::ADDR_INSTR: instr_next = pwdata[13:0];
        sbx_pkg::ADDR_ACC: acc_next = wbyte;
        sbx_pkg::ADDR_STATUS: begin
          c_next = wbyte[sbx_pkg::STAT_C_BIT];
          nib_next = wbyte[sbx_pkg::STAT_NIB_BIT];
          z_next = wbyte[sbx_pkg::STAT_Z_BIT];
          if (wbyte[sbx_pkg::STAT_BADOP_BIT]) begin
            badop_next = 1'b0;
          end
        end
        sbx_pkg::ADDR_FADDR: faddr_next = wbyte[6:0];
        sbx_pkg::ADDR_FDATA: mem_we = 1'b1;
        default: ;
      endcase
    end

    unique case (st_reg)
      sbx_pkg::ST_IDLE: begin
        if (wr_ok && paddr == sbx_pkg::ADDR_CTRL &&
            wbyte[sbx_pkg::CTRL_ISSUE_BIT]) begin
          st_next = sbx_pkg::ST_RUN;
        end
      end
      sbx_pkg::ST_RUN: begin
        if (q1) begin
          if ((instr_reg & sbx_pkg::LIT_MASK) == sbx_pkg::LIT_PAT) begin
            kind_next = sbx_pkg::K_LIT;
          end else if ((instr_reg & sbx_pkg::REG_MASK) ==
                       sbx_pkg::REG_PAT) begin
            kind_next = sbx_pkg::K_REG;
          end else if (instr_reg == sbx_pkg::SLEEP_CODE) begin
            kind_next = sbx_pkg::K_SLEEP;
          end else begin
            kind_next = sbx_pkg::K_NONE;
            badop_next = 1'b1;
          end
        end
        if (q2) begin
          // Literal comes from the low byte; the x bit is never looked at
          op_next = (kind_reg == sbx_pkg::K_LIT) ? instr_reg[7:0]
                    : file_mem[instr_reg[6:0]];
        end
        if (q3) begin
          res_next = alu_bus.diff;
          nc_next = alu_bus.carry;
          ndc_next = alu_bus.nib_carry;
          nz_next = alu_bus.zero;
        end
        if (q4) begin
          st_next = (kind_reg == sbx_pkg::K_SLEEP) ?
                    sbx_pkg::ST_SLEEP : sbx_pkg::ST_IDLE;
          if (kind_reg == sbx_pkg::K_LIT || kind_reg == sbx_pkg::K_REG) begin
            c_next = nc_reg;
            nib_next = ndc_reg;
            z_next = nz_reg;
          end
          if (kind_reg == sbx_pkg::K_LIT ||
              (kind_reg == sbx_pkg::K_REG && !dest_reg)) begin
            acc_next = res_reg;
          end
          if (kind_reg == sbx_pkg::K_REG && dest_reg) begin
            mem_we = 1'b1;
            mem_addr = instr_reg[6:0];
            mem_wdata = res_reg;
          end
        end
      end
      sbx_pkg::ST_SLEEP: begin
        // Phase clock is held still; only a software wake ends sleep, and the next issue restarts it
        if (wr_ok && paddr == sbx_pkg::ADDR_CTRL &&
            wbyte[sbx_pkg::CTRL_WAKE_BIT]) begin
          st_next = sbx_pkg::ST_IDLE;
        end
      end
      default: st_next = sbx_pkg::ST_IDLE;
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_reg <= sbx_pkg::ST_IDLE;
      kind_reg <= sbx_pkg::K_NONE;
      instr_reg <= sbx_pkg::INSTR_RST;
      acc_reg <= sbx_pkg::ACC_RST;
      faddr_reg <= sbx_pkg::FADDR_RST;
      op_reg <= 8'h00;
      res_reg <= 8'h00;
      nc_reg <= sbx_pkg::FLAG_RST;
      ndc_reg <= sbx_pkg::FLAG_RST;
      nz_reg <= sbx_pkg::FLAG_RST;
      c_reg <= sbx_pkg::FLAG_RST;
      nib_reg <= sbx_pkg::FLAG_RST;
      z_reg <= sbx_pkg::FLAG_RST;
      badop_reg <= sbx_pkg::FLAG_RST;
      prdata_reg <= 32'h00000000;
    end else begin
      st_reg <= st_next;
      kind_reg <= kind_next;
      instr_reg <= instr_next;
      acc_reg <= acc_next;
      faddr_reg <= faddr_next;
      op_reg <= op_next;
      res_reg <= res_next;
      nc_reg <= nc_next;
      ndc_reg <= ndc_next;
      nz_reg <= nz_next;
      c_reg <= c_next;
      nib_reg <= nib_next;
      z_reg <= z_next;
      badop_reg <= badop_next;
      prdata_reg <= prdata_next;
    end
  end

  // Data registers carry no reset, as in the core they model
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      file_mem[mem_addr] <= mem_wdata;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_sleep_q4;
    $rose(core_sleep) |->
      $past(q4) && $past(kind_reg) == sbx_pkg::K_SLEEP;
  endproperty
  a_sleep_q4: assert property (p_sleep_q4)
    else $error("sleep entered outside Q4 of power-down");

  property p_lit_to_acc;
    q4 && kind_reg == sbx_pkg::K_LIT |=> acc_reg == $past(res_reg);
  endproperty
  a_lit_to_acc: assert property (p_lit_to_acc)
    else $error("literal result not written to accumulator");

  property p_lit_wrap;
    q3 && kind_reg == sbx_pkg::K_LIT |=>
      res_reg == 8'($past(instr_reg[7:0]) - $past(acc_reg));
  endproperty
  a_lit_wrap: assert property (p_lit_wrap)
    else $error("literal difference wrong");

  property p_reg_operand;
    q2 && kind_reg == sbx_pkg::K_REG |=>
      op_reg == $past(file_mem[instr_reg[6:0]]);
  endproperty
  a_reg_operand: assert property (p_reg_operand)
    else $error("register operand not read from addressed register");

  property p_carry;
    q4 && (kind_reg == sbx_pkg::K_LIT || kind_reg == sbx_pkg::K_REG) |=>
      c_reg == ($past(op_reg) >= $past(acc_reg));
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry does not reflect borrow");

  property p_dec_lit;
    q1 && (instr_reg & sbx_pkg::LIT_MASK) == sbx_pkg::LIT_PAT |=>
      kind_reg == sbx_pkg::K_LIT;
  endproperty
  a_dec_lit: assert property (p_dec_lit)
    else $error("literal form not decoded");

  property p_dec_reg;
    q1 && (instr_reg & sbx_pkg::REG_MASK) == sbx_pkg::REG_PAT |=>
      kind_reg == sbx_pkg::K_REG;
  endproperty
  a_dec_reg: assert property (p_dec_reg)
    else $error("register form not decoded");

  property p_dest;
    q4 && kind_reg == sbx_pkg::K_REG |->
      (dest_reg ? (mem_we && mem_addr == instr_reg[6:0] &&
                   acc_next == acc_reg)
                : (!mem_we && acc_next == res_reg));
  endproperty
  a_dest: assert property (p_dest)
    else $error("destination select misrouted");

  property p_sleep_still;
    core_sleep |-> !q_stb && q_sel == sbx_pkg::PHASE_FIRST;
  endproperty
  a_sleep_still: assert property (p_sleep_still)
    else $error("phases advance while asleep");

  property p_zero_nib;
    q4 && (kind_reg == sbx_pkg::K_LIT || kind_reg == sbx_pkg::K_REG) |=>
      z_reg == ($past(res_reg) == 8'h00) &&
      nib_reg == ($past(op_reg[3:0]) >= $past(acc_reg[3:0]));
  endproperty
  a_zero_nib: assert property (p_zero_nib)
    else $error("zero or nibble borrow flag wrong");
endmodule

`default_nettype wire

// ===== testbench/test_sbx_sub_exec.sv
`timescale 1ns/10ps
`default_nettype none

module test_sbx_sub_exec;
  // ****
  // Harness
  // ****
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, core_sleep;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0] pstrb;
  logic ev;
  int err_count, samples_checked;
  logic [7:0] tk [6] = '{8'h02, 8'h02, 8'h02, 8'h00, 8'h00, 8'hff};
  logic [7:0] tw [6] = '{8'h01, 8'h02, 8'h03, 8'h00, 8'hff, 8'h00};
  logic [7:0] raddr [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};

  sbx_sub_exec i_dut (.core_clk(core_clk), .rst(rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_sleep(core_sleep));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ****
  // Tasks
  // ****
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole run is a few thousand cycles; this margin only catches hangs
  initial begin
    repeat (40000) @(posedge core_clk);
    err_count++;
    finish_test();
  end

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp,
                          input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp,
                          input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  // Returns {zero, nibble, carry, result}
  function automatic logic [10:0] sub_exp(input logic [7:0] a,
                                          input logic [7:0] b);
    logic [7:0] r;
    r = a - b;
    return {(r == 8'h00), (a[3:0] >= b[3:0]), (a >= b), r};
  endfunction

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] r, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, 4'hf, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(a, 1'b0, 32'h0, 4'h0, r, e);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      rd(sbx_pkg::ADDR_STATUS, rv);
      n++;
    end while (rv[sbx_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 40);
    chk_flag(rv[sbx_pkg::STAT_BUSY_BIT], 1'b0, "busy");
  endtask

  task automatic run(input logic [13:0] ins);
    wr(sbx_pkg::ADDR_INSTR, {18'h0, ins});
    wr(sbx_pkg::ADDR_CTRL, 32'h1);
    wait_idle();
  endtask

  // Flags preset to the opposite of what is expected, so stale ones show
  task automatic prep(input logic [7:0] w, input logic [10:0] e);
    wr(sbx_pkg::ADDR_ACC, {24'h0, w});
    wr(sbx_pkg::ADDR_STATUS, {29'h0, ~e[10:8]});
  endtask

  task automatic check_out(input logic [7:0] got, input logic [10:0] e);
    chk_data({24'h0, got}, {24'h0, e[7:0]}, "result");
    rd(sbx_pkg::ADDR_STATUS, rv);
    chk_flag(rv[sbx_pkg::STAT_C_BIT], e[8], "carry");
    chk_flag(rv[sbx_pkg::STAT_NIB_BIT], e[9], "nibble");
    chk_flag(rv[sbx_pkg::STAT_Z_BIT], e[10], "zero");
  endtask

  // ****
  // Tests
  // ****
  initial begin
    logic [7:0] k, w, v, a;
    logic [6:0] f;
    logic [10:0] e;
    logic d;
    int n;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    err_count = 0;
    samples_checked = 0;
    void'($urandom(75676));
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    foreach (raddr[i]) begin
      rd(raddr[i], rv);
      chk_data(rv, 32'h0, "reset");
    end
    chk_flag(core_sleep, 1'b0, "reset sleep");
    $display("test reset done");

    for (int i = 0; i < 30; i++) begin
      k = (i < 6) ? tk[i] : 8'($urandom);
      w = (i < 6) ? tw[i] : 8'($urandom);
      e = sub_exp(k, w);
      prep(w, e);
      run({5'b11110, 1'($urandom), k});
      rd(sbx_pkg::ADDR_ACC, rv);
      check_out(rv[7:0], e);
    end
    $display("test literal done");

    for (int i = 0; i < 30; i++) begin
      f = 7'($urandom);
      v = 8'($urandom);
      w = 8'($urandom);
      d = i[0];
      e = sub_exp(v, w);
      wr(sbx_pkg::ADDR_FADDR, {25'h0, f});
      wr(sbx_pkg::ADDR_FDATA, {24'h0, v});
      // Pointer moved away: the operand must come from the opcode field
      wr(sbx_pkg::ADDR_FADDR, {25'h0, f ^ 7'h01});
      prep(w, e);
      run({6'b000010, d, f});
      wr(sbx_pkg::ADDR_FADDR, {25'h0, f});
      rd(sbx_pkg::ADDR_ACC, rv);
      a = rv[7:0];
      rd(sbx_pkg::ADDR_FDATA, rv);
      chk_data({24'h0, d ? a : rv[7:0]}, {24'h0, d ? w : v}, "kept");
      check_out(d ? rv[7:0] : a, e);
    end
    $display("test register done");

    e = sub_exp(8'h09, 8'h03);
    prep(8'h03, e);
    wr(sbx_pkg::ADDR_INSTR, 32'h3c09);
    wr(sbx_pkg::ADDR_CTRL, 32'h1);
    apb(sbx_pkg::ADDR_ACC, 1'b1, 32'h55, 4'hf, rv, ev);
    chk_flag(ev, 1'b1, "busy write");
    wait_idle();
    rd(sbx_pkg::ADDR_ACC, rv);
    check_out(rv[7:0], e);
    apb(sbx_pkg::ADDR_ACC, 1'b1, 32'h77, 4'he, rv, ev);
    apb(8'h18, 1'b0, 32'h0, 4'h0, rv, ev);
    chk_flag(ev, 1'b1, "unmapped");
    chk_data(rv, 32'h0, "unmapped data");
    run(14'h0700);
    rd(sbx_pkg::ADDR_STATUS, rv);
    chk_flag(rv[sbx_pkg::STAT_BADOP_BIT], 1'b1, "badop");
    rd(sbx_pkg::ADDR_ACC, rv);
    chk_data(rv, {24'h0, e[7:0]}, "acc kept");
    wr(sbx_pkg::ADDR_STATUS, 32'h20);
    rd(sbx_pkg::ADDR_STATUS, rv);
    chk_flag(rv[sbx_pkg::STAT_BADOP_BIT], 1'b0, "badop clear");
    $display("test refusal done");

    wr(sbx_pkg::ADDR_STATUS, 32'h5);
    wr(sbx_pkg::ADDR_INSTR, 32'h0063);
    wr(sbx_pkg::ADDR_CTRL, 32'h1);
    n = 0;
    while (core_sleep !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk_data(32'(n), 32'(4 * sbx_pkg::PHASE_DIV), "sleep phase");
    wr(sbx_pkg::ADDR_CTRL, 32'h1);
    repeat (20) @(posedge core_clk);
    rd(sbx_pkg::ADDR_ACC, rv);
    chk_data(rv, {24'h0, e[7:0]}, "asleep acc");
    rd(sbx_pkg::ADDR_STATUS, rv);
    chk_flag(rv[sbx_pkg::STAT_SLEEP_BIT], 1'b1, "asleep");
    chk_data({29'h0, rv[2:0]}, 32'h5, "sleep flags");
    wr(sbx_pkg::ADDR_CTRL, 32'h2);
    @(posedge core_clk);
    #1;
    chk_flag(core_sleep, 1'b0, "wake");
    e = sub_exp(8'h10, 8'h01);
    prep(8'h01, e);
    run(14'h3c10);
    rd(sbx_pkg::ADDR_ACC, rv);
    check_out(rv[7:0], e);
    $display("test sleep done");
    finish_test();
  end
endmodule

`default_nettype wire
